// ==== gsr_params.svh ====
`ifndef GSR_PARAMS_SVH
`define GSR_PARAMS_SVH

// ----------------------------------------------------------------------
// Status byte bit positions
// ----------------------------------------------------------------------
`define GSR_STB_MSS 6
`define GSR_STB_ESB 5
`define GSR_STB_MAV 4
`define GSR_STB_TRIP 1
`define GSR_STB_STATE 0
`define GSR_STB_USED 8'h73

// ----------------------------------------------------------------------
// Standard event status bit positions
// ----------------------------------------------------------------------
`define GSR_ESR_PON 7
`define GSR_ESR_CME 5
`define GSR_ESR_EXE 4
`define GSR_ESR_QYE 2
`define GSR_ESR_OPC 0

// ----------------------------------------------------------------------
// Reset values, query error codes and used-bit masks
// ----------------------------------------------------------------------
`define GSR_ESR_RST 8'h80
`define GSR_ZERO8 8'h00
`define GSR_QER_UNTERM 8'h03
`define GSR_QER_DEADLOCK 8'h02
`define GSR_QER_INTERRUPT 8'h01
`define GSR_TRIP_USED 8'h86
`define GSR_STATE_USED 8'h8E
`define GSR_PPE_RST 4'h0

`endif

// ==== gsr_pkg.sv ====
package gsr_pkg;

    // ------------------------------------------------------------------
    // Command codes delivered by the command parser
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        GSR_CMD_NOP = 5'h00,
        GSR_CMD_SET_SRE = 5'h01,
        GSR_CMD_SET_PRE = 5'h02,
        GSR_CMD_SET_ISE = 5'h03,
        GSR_CMD_SET_ITE = 5'h04,
        GSR_CMD_SET_ESE = 5'h05,
        GSR_CMD_SET_EER = 5'h06,
        GSR_CMD_Q_STB = 5'h07,
        GSR_CMD_Q_SRE = 5'h08,
        GSR_CMD_Q_PRE = 5'h09,
        GSR_CMD_Q_IST = 5'h0A,
        GSR_CMD_Q_ISR = 5'h0B,
        GSR_CMD_Q_ITR = 5'h0C,
        GSR_CMD_Q_ISE = 5'h0D,
        GSR_CMD_Q_ITE = 5'h0E,
        GSR_CMD_Q_ESR = 5'h0F,
        GSR_CMD_Q_ESE = 5'h10,
        GSR_CMD_Q_EER = 5'h11,
        GSR_CMD_Q_QER = 5'h12,
        GSR_CMD_CLS = 5'h13,
        GSR_CMD_OPC = 5'h14,
        GSR_CMD_PPE = 5'h15,
        GSR_CMD_PPD = 5'h16,
        GSR_CMD_PPU = 5'h17,
        GSR_CMD_INP_ON = 5'h18,
        GSR_CMD_INP_OFF = 5'h19
    } gsr_cmd_e;

    // ------------------------------------------------------------------
    // Response formatter state, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        GSR_FMT_IDLE = 2'b01,
        GSR_FMT_WAIT = 2'b10
    } gsr_fmt_e;

    typedef logic [7:0] gsr_byte_t;

endpackage

// ==== gsr_eval_if.sv ====
`timescale 1ns/100ps
`default_nettype none

// Register contents out to the summary evaluator, summaries back
interface gsr_eval_if;
    import gsr_pkg::*;
    gsr_byte_t esr; // Standard event status
    gsr_byte_t ese; // Its enable
    gsr_byte_t input_trip_register; // Input trip
    gsr_byte_t input_trip_enable; // Its enable
    gsr_byte_t input_state_register; // Input state
    gsr_byte_t input_state_enable; // Its enable
    gsr_byte_t service_request_enable; // Service request enable
    gsr_byte_t pre; // Parallel poll enable
    logic mav; // Message available
    gsr_byte_t stb; // Status byte with summary in bit 6
    logic ist; // Parallel poll local message
    modport regs (output esr, ese, input_trip_register, input_trip_enable, input_state_register, input_state_enable, service_request_enable, pre, mav, input stb, ist);
    modport eval (input esr, ese, input_trip_register, input_trip_enable, input_state_register, input_state_enable, service_request_enable, pre, mav, output stb, ist);
endinterface

`default_nettype wire

// ==== gsr_summary.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "gsr_params.svh"

// Combinational summary of all masked registers
module gsr_summary (
    gsr_eval_if.eval ev
);
    import gsr_pkg::*;

    gsr_byte_t sum; // Working status byte

    // Any bit set in both operands
    function automatic logic any_match(input gsr_byte_t a, input gsr_byte_t b);
        any_match = |(a & b);
    endfunction

    // ------------------------------------------------------------------
    // Summary bits, master summary and ist
    // ------------------------------------------------------------------
    always_comb begin
        sum = `GSR_ZERO8; // Bits 7, 3, 2 stay zero
        sum[`GSR_STB_ESB] = any_match(ev.esr, ev.ese);
        sum[`GSR_STB_MAV] = ev.mav;
        sum[`GSR_STB_TRIP] = any_match(ev.input_trip_register, ev.input_trip_enable);
        sum[`GSR_STB_STATE] = any_match(ev.input_state_register, ev.input_state_enable);
        sum[`GSR_STB_MSS] = any_match(sum, ev.service_request_enable);
        ev.stb = sum;
        ev.ist = any_match(sum, ev.pre);
    end

endmodule

`default_nettype wire

// ==== gsr_status.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "gsr_params.svh"

// Summary of operation
// - Enabled status bits raise summary and service request
// - Status query shows summary; serial poll shows request
// - Status byte bits 7, 3, 2 read zero
// - Request clears on poll; summary follows condition
// - Bit 5 summarises enabled standard events
// - Bit 4 set on response, cleared after terminator
// - Bit 1 summarises enabled input trips
// - Bit 0 summarises enabled input states
// - ist is masked status byte OR; queryable
// - Parallel poll mask written and read back
// - Poll line and sense set, released by commands
// - Poll response never drives data lines high
// - Talk with nothing pending: code 3, reset parser
// - Queue full while waiting: code 2, discard
// - Terminator or two ENDs waiting: code 1, discard
// - Power-on: events 128, other registers zero
// - Trip, error and event registers clear on query
// - State register shows live conditions; trip register latches them
// - Service request mask written and read back
// - Input enable off at power-on unless retained
// - Query error bit 2, execution 4, power-on 7

module gsr_status (
    input wire logic clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire gsr_pkg::gsr_cmd_e cmd_code,
    input wire gsr_pkg::gsr_byte_t cmd_data,
    input wire logic resp_ready,
    input wire logic term_sent,
    input wire logic queue_empty,
    input wire logic queue_full,
    input wire logic term_parsed,
    input wire logic multi_end,
    input wire logic cmd_error,
    input wire logic spoll_done,
    input wire logic talk_pin,
    input wire logic ppoll_pin,
    input wire gsr_pkg::gsr_byte_t trip_cond,
    input wire gsr_pkg::gsr_byte_t state_cond,
    input wire logic retain_cfg,
    input wire logic last_enable,
    output logic resp_valid,
    output gsr_pkg::gsr_byte_t resp_data,
    output logic srq,
    output logic ist,
    output gsr_pkg::gsr_byte_t spoll_byte,
    output logic mav,
    output logic parser_reset,
    output logic fmt_discard,
    output logic input_enable,
    output gsr_pkg::gsr_byte_t dio_o,
    output gsr_pkg::gsr_byte_t dio_oe
);
    import gsr_pkg::*;

    // ------------------------------------------------------------------
    // Registers and their next values
    // ------------------------------------------------------------------
    gsr_byte_t sre_reg, sre_next; // Service request enable
    gsr_byte_t pre_reg, pre_next; // Parallel poll enable
    gsr_byte_t ise_reg, ise_next; // Input state enable
    gsr_byte_t ite_reg, ite_next; // Input trip enable
    gsr_byte_t ese_reg, ese_next; // Event status enable
    gsr_byte_t esr_reg, esr_next; // Event status
    gsr_byte_t eer_reg, eer_next; // Execution error code
    gsr_byte_t qer_reg, qer_next; // Query error code
    gsr_byte_t itr_reg, itr_next; // Sticky input trips
    gsr_byte_t stb_reg, stb_next; // Status byte, summary in bit 6
    gsr_byte_t spb_reg, spb_next; // Serial poll byte
    gsr_byte_t rdat_reg, rdat_next; // Query answer
    gsr_byte_t oe_reg, oe_next; // Poll line enables
    gsr_byte_t dio_reg, dio_next; // Poll line data, always low
    logic [3:0] ppe_reg, ppe_next; // Poll sense and line
    logic ppen_reg, ppen_next; // Poll response configured
    logic rqs_reg, rqs_next; // Request service
    logic mss_d_reg, mss_d_next; // Summary one cycle back
    logic ist_reg, ist_next; // ist local message
    logic rval_reg, rval_next; // Answer strobe
    logic prst_reg, prst_next; // Parser reset strobe
    logic disc_reg, disc_next; // Response discard strobe
    logic inen_reg, inen_next; // Load input enable
    logic init_reg, init_next; // Power-on capture done
    logic talk_d_reg, talk_d_next; // Talk level one cycle back
    gsr_fmt_e fmt_reg, fmt_next; // Response formatter state
    logic talk_s1, talk_s2, pp_s1, pp_s2; // Pin synchronisers

    gsr_byte_t isr_live; // Present input state
    logic talk_rise; // Newly addressed to talk
    logic waiting; // Response held for controller
    logic q_unterm, q_dead, q_trip_summary_bit; // Query error events

    // ------------------------------------------------------------------
    // Summary evaluator
    // ------------------------------------------------------------------
    gsr_eval_if ev ();
    assign ev.esr = esr_reg;
    assign ev.ese = ese_reg;
    assign ev.input_trip_register = itr_reg;
    assign ev.input_trip_enable = ite_reg;
    assign ev.input_state_register = isr_live;
    assign ev.input_state_enable = ise_reg;
    assign ev.service_request_enable = sre_reg;
    assign ev.pre = pre_reg;
    assign ev.mav = (fmt_reg == GSR_FMT_WAIT);

    gsr_summary u_summary (
        .ev(ev)
    );

    // Pins from the bus pass two flops before use
    always_ff @(posedge clk) begin
        if (rst) begin
            talk_s1 <= 1'b0;
            talk_s2 <= 1'b0;
            pp_s1 <= 1'b0;
            pp_s2 <= 1'b0;
        end else begin
            talk_s1 <= talk_pin;
            talk_s2 <= talk_s1;
            pp_s1 <= ppoll_pin;
            pp_s2 <= pp_s1;
        end
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        // Live state: bit 0 reports input disabled
        isr_live = state_cond & `GSR_STATE_USED;
        isr_live[0] = ~inen_reg;
        waiting = (fmt_reg == GSR_FMT_WAIT);
        talk_rise = talk_s2 & ~talk_d_reg;
        q_unterm = talk_rise & ~waiting & queue_empty;
        q_dead = waiting & queue_full;
        q_trip_summary_bit = waiting & ~queue_full & (term_parsed | multi_end);
        // Defaults hold state, strobes fall
        sre_next = sre_reg;
        pre_next = pre_reg;
        ise_next = ise_reg;
        ite_next = ite_reg;
        ese_next = ese_reg;
        esr_next = esr_reg;
        eer_next = eer_reg;
        qer_next = qer_reg;
        itr_next = itr_reg;
        ppe_next = ppe_reg;
        ppen_next = ppen_reg;
        inen_next = inen_reg;
        rdat_next = `GSR_ZERO8;
        rval_next = 1'b0;
        prst_next = 1'b0;
        disc_next = 1'b0;
        talk_d_next = talk_s2;
        init_next = 1'b1;
        dio_next = `GSR_ZERO8; // Pull-up is passive only
        // Retained enable caught once after reset
        if (!init_reg) begin
            inen_next = retain_cfg & last_enable;
        end
        // Parser command and query handling
        if (cmd_valid) begin
            case (cmd_code)
                GSR_CMD_SET_SRE: sre_next = cmd_data;
                GSR_CMD_SET_PRE: pre_next = cmd_data;
                GSR_CMD_SET_ISE: ise_next = cmd_data;
                GSR_CMD_SET_ITE: ite_next = cmd_data;
                GSR_CMD_SET_ESE: ese_next = cmd_data;
                GSR_CMD_SET_EER: eer_next = cmd_data;
                GSR_CMD_Q_STB: begin
                    rval_next = 1'b1;
                    rdat_next = stb_reg; // Summary in bit 6
                end
                GSR_CMD_Q_SRE: begin
                    rval_next = 1'b1;
                    rdat_next = sre_reg;
                end
                GSR_CMD_Q_PRE: begin
                    rval_next = 1'b1;
                    rdat_next = pre_reg;
                end
                GSR_CMD_Q_IST: begin
                    rval_next = 1'b1;
                    rdat_next = {7'h00, ist_reg};
                end
                GSR_CMD_Q_ISR: begin
                    rval_next = 1'b1;
                    rdat_next = isr_live;
                end
                GSR_CMD_Q_ITR: begin
                    rval_next = 1'b1;
                    rdat_next = itr_reg;
                    itr_next = `GSR_ZERO8;
                end
                GSR_CMD_Q_ISE: begin
                    rval_next = 1'b1;
                    rdat_next = ise_reg;
                end
                GSR_CMD_Q_ITE: begin
                    rval_next = 1'b1;
                    rdat_next = ite_reg;
                end
                GSR_CMD_Q_ESR: begin
                    rval_next = 1'b1;
                    rdat_next = esr_reg;
                    esr_next = `GSR_ZERO8;
                end
                GSR_CMD_Q_ESE: begin
                    rval_next = 1'b1;
                    rdat_next = ese_reg;
                end
                GSR_CMD_Q_EER: begin
                    rval_next = 1'b1;
                    rdat_next = eer_reg;
                    eer_next = `GSR_ZERO8;
                end
                GSR_CMD_Q_QER: begin
                    rval_next = 1'b1;
                    rdat_next = qer_reg;
                    qer_next = `GSR_ZERO8;
                end
                GSR_CMD_CLS: begin
                    // Clear status empties all clear-on-read registers
                    itr_next = `GSR_ZERO8;
                    esr_next = `GSR_ZERO8;
                    eer_next = `GSR_ZERO8;
                    qer_next = `GSR_ZERO8;
                end
                GSR_CMD_OPC: esr_next[`GSR_ESR_OPC] = 1'b1;
                GSR_CMD_PPE: begin
                    ppe_next = cmd_data[3:0]; // Sense and line
                    ppen_next = 1'b1;
                end
                GSR_CMD_PPD, GSR_CMD_PPU: ppen_next = 1'b0;
                GSR_CMD_INP_ON: inen_next = 1'b1;
                GSR_CMD_INP_OFF: inen_next = 1'b0;
                default: rval_next = 1'b0;
            endcase
        end
        // Events set after clears, so the set wins
        itr_next = itr_next | (trip_cond & `GSR_TRIP_USED);
        if (cmd_error) begin
            esr_next[`GSR_ESR_CME] = 1'b1;
        end
        if (cmd_valid && cmd_code == GSR_CMD_SET_EER && cmd_data != `GSR_ZERO8) begin
            esr_next[`GSR_ESR_EXE] = 1'b1;
        end
        // Query protocol errors, deadlock ahead of interrupted
        if (q_unterm) begin
            qer_next = `GSR_QER_UNTERM;
            prst_next = 1'b1;
        end else if (q_dead) begin
            qer_next = `GSR_QER_DEADLOCK;
            disc_next = 1'b1;
        end else if (q_trip_summary_bit) begin
            qer_next = `GSR_QER_INTERRUPT;
            disc_next = 1'b1;
        end
        if (q_unterm | q_dead | q_trip_summary_bit) begin
            esr_next[`GSR_ESR_QYE] = 1'b1;
        end
        // Response formatter state
        case (fmt_reg)
            GSR_FMT_IDLE: begin
                fmt_next = resp_ready ? GSR_FMT_WAIT : GSR_FMT_IDLE;
            end
            GSR_FMT_WAIT: begin
                // Terminator sent or response discarded ends the wait
                if (term_sent | q_dead | q_trip_summary_bit) begin
                    fmt_next = GSR_FMT_IDLE;
                end else begin
                    fmt_next = GSR_FMT_WAIT;
                end
            end
            default: fmt_next = GSR_FMT_IDLE;
        endcase
        // Summaries registered one clock after the sources
        stb_next = ev.stb;
        ist_next = ev.ist;
        mss_d_next = ev.stb[`GSR_STB_MSS];
        // Request raised on a new summary, poll clears it
        rqs_next = rqs_reg & ~spoll_done;
        if (ev.stb[`GSR_STB_MSS] & ~mss_d_reg) begin
            rqs_next = 1'b1;
        end
        spb_next = ev.stb;
        spb_next[`GSR_STB_MSS] = rqs_next;
        // Poll response pulls the chosen line low on sense match
        oe_next = `GSR_ZERO8;
        if (pp_s2 && ppen_reg && (ist_reg == ppe_reg[3])) begin
            oe_next = 8'h01 << ppe_reg[2:0];
        end
    end

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            // Power-on values
            sre_reg <= `GSR_ZERO8;
            pre_reg <= `GSR_ZERO8;
            ise_reg <= `GSR_ZERO8;
            ite_reg <= `GSR_ZERO8;
            ese_reg <= `GSR_ZERO8;
            esr_reg <= `GSR_ESR_RST;
            eer_reg <= `GSR_ZERO8;
            qer_reg <= `GSR_ZERO8;
            itr_reg <= `GSR_ZERO8;
            stb_reg <= `GSR_ZERO8;
            spb_reg <= `GSR_ZERO8;
            rdat_reg <= `GSR_ZERO8;
            oe_reg <= `GSR_ZERO8;
            dio_reg <= `GSR_ZERO8;
            ppe_reg <= `GSR_PPE_RST;
            ppen_reg <= 1'b0;
            rqs_reg <= 1'b0;
            mss_d_reg <= 1'b0;
            ist_reg <= 1'b0;
            rval_reg <= 1'b0;
            prst_reg <= 1'b0;
            disc_reg <= 1'b0;
            inen_reg <= 1'b0;
            init_reg <= 1'b0;
            talk_d_reg <= 1'b0;
            fmt_reg <= GSR_FMT_IDLE;
        end else begin
            sre_reg <= sre_next;
            pre_reg <= pre_next;
            ise_reg <= ise_next;
            ite_reg <= ite_next;
            ese_reg <= ese_next;
            esr_reg <= esr_next;
            eer_reg <= eer_next;
            qer_reg <= qer_next;
            itr_reg <= itr_next;
            stb_reg <= stb_next;
            spb_reg <= spb_next;
            rdat_reg <= rdat_next;
            oe_reg <= oe_next;
            dio_reg <= dio_next;
            ppe_reg <= ppe_next;
            ppen_reg <= ppen_next;
            rqs_reg <= rqs_next;
            mss_d_reg <= mss_d_next;
            ist_reg <= ist_next;
            rval_reg <= rval_next;
            prst_reg <= prst_next;
            disc_reg <= disc_next;
            inen_reg <= inen_next;
            init_reg <= init_next;
            talk_d_reg <= talk_d_next;
            fmt_reg <= fmt_next;
        end
    end

    // Outputs straight from flops
    assign resp_valid = rval_reg;
    assign resp_data = rdat_reg;
    assign srq = rqs_reg;
    assign ist = ist_reg;
    assign spoll_byte = spb_reg;
    assign mav = stb_reg[`GSR_STB_MAV];
    assign parser_reset = prst_reg;
    assign fmt_discard = disc_reg;
    assign input_enable = inen_reg;
    assign dio_o = dio_reg;
    assign dio_oe = oe_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_mss_from_sre: assert property (
        @(posedge clk) disable iff (rst)
        ##1 stb_reg[6] == |($past(sre_reg[5:0]) & stb_reg[5:0]))
        else $error("summary bit disagrees with enabled status bits");
    chk_unused_zero: assert property (
        @(posedge clk) disable iff (rst)
        (stb_reg & ~`GSR_STB_USED) == 8'h00 && (spb_reg & 8'h8C) == 8'h00)
        else $error("unused status byte bits set");
    chk_rqs_poll_clear: assert property (
        @(posedge clk) disable iff (rst)
        spoll_done && !(ev.stb[6] && !mss_d_reg) |=> !srq ##1 spoll_byte[6] == srq)
        else $error("request not cleared by serial poll");
    chk_mav_terminator: assert property (
        @(posedge clk) disable iff (rst)
        fmt_reg == GSR_FMT_WAIT && term_sent |=> fmt_reg == GSR_FMT_IDLE ##1 !mav)
        else $error("message available not cleared after terminator");
    chk_unterm_code: assert property (
        @(posedge clk) disable iff (rst)
        q_unterm |=> qer_reg == 8'h03 && esr_reg[2] && parser_reset)
        else $error("unterminated error not recorded");
    chk_deadlock_code: assert property (
        @(posedge clk) disable iff (rst)
        waiting && queue_full |=> qer_reg == 8'h02 && fmt_discard && !ev.mav)
        else $error("deadlock error not recorded");
    chk_interrupt_code: assert property (
        @(posedge clk) disable iff (rst)
        q_trip_summary_bit |=> qer_reg == 8'h01 && esr_reg[2] && fmt_reg == GSR_FMT_IDLE)
        else $error("interrupted error not recorded");
    chk_ist_value: assert property (
        @(posedge clk) disable iff (rst)
        ##1 ist_reg == |(stb_reg & $past(pre_reg)))
        else $error("ist disagrees with masked status byte");
    chk_no_drive_high: assert property (
        @(posedge clk) disable iff (rst)
        dio_o == 8'h00 && $countones(dio_oe) <= 1)
        else $error("poll response drives a line high");
    chk_power_on: assert property (
        @(posedge clk)
        rst |=> esr_reg == 8'h80 && sre_reg == 8'h00 && qer_reg == 8'h00 && stb_reg == 8'h00)
        else $error("power-on values wrong");
    chk_qer_read_clear: assert property (
        @(posedge clk) disable iff (rst)
        cmd_valid && cmd_code == GSR_CMD_Q_QER && !(q_unterm || q_dead || q_trip_summary_bit)
        |=> qer_reg == 8'h00 && resp_valid)
        else $error("query error code not cleared by its query");

endmodule

`default_nettype wire

// ==== gsr_ctl_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// Bus controller: addresses the device to talk and runs serial and parallel polls
module gsr_ctl_model (
    input wire logic clk,
    output logic talk_pin,
    output logic ppoll_pin,
    output logic spoll_done
);
    initial begin
        talk_pin = 1'b0;
        ppoll_pin = 1'b0;
        spoll_done = 1'b0;
    end
    // Status byte read by a serial poll, one-cycle strobe
    task automatic spoll();
        @(posedge clk);
        #1 spoll_done = 1'b1;
        @(posedge clk);
        #1 spoll_done = 1'b0;
    endtask
    // Addressed to talk for a few cycles, long enough to pass the synchroniser
    task automatic talk();
        @(posedge clk);
        #1 talk_pin = 1'b1;
        repeat (4) @(posedge clk);
        #1 talk_pin = 1'b0;
    endtask
    // Parallel poll held or released after the poll line was configured
    task automatic ppoll(input logic v);
        @(posedge clk);
        #1 ppoll_pin = v;
    endtask
endmodule
`default_nettype wire

// ==== tb_gsr_status.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_gsr_status;
    import gsr_pkg::*;
    logic clk = 0, rst = 1, cv = 0, rr = 0, ts = 0, qe = 1, qf = 0, tp = 0;
    gsr_cmd_e cc = GSR_CMD_NOP;
    gsr_byte_t cd = 8'h00, tc = 8'h00, sc = 8'h00, r, rd, sb, doo, doe;
    logic ce = 0; // Syntax error strobe from the parser
    gsr_byte_t exq[$]; // Expected query answers, oldest first
    logic rv, srq, ist, mav, pr, fd, ie, talk, pp, sd;
    int failures = 0, comparisons = 0;
    gsr_status gsr_status_i (.clk(clk), .rst(rst), .cmd_valid(cv), .cmd_code(cc), .cmd_data(cd),
        .resp_ready(rr), .term_sent(ts), .queue_empty(qe), .queue_full(qf), .term_parsed(tp),
        .multi_end(1'b0), .cmd_error(ce), .spoll_done(sd), .talk_pin(talk), .ppoll_pin(pp),
        .trip_cond(tc), .state_cond(sc), .retain_cfg(1'b0), .last_enable(1'b0),
        .resp_valid(rv), .resp_data(rd), .srq(srq), .ist(ist), .spoll_byte(sb), .mav(mav),
        .parser_reset(pr), .fmt_discard(fd), .input_enable(ie), .dio_o(doo), .dio_oe(doe));
    gsr_ctl_model gsr_ctl_model_i (.clk(clk), .talk_pin(talk), .ppoll_pin(pp), .spoll_done(sd));
    initial forever #5 clk = ~clk;
    task automatic cmp(input string n, input gsr_byte_t e, input gsr_byte_t g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmd(input gsr_cmd_e c, input gsr_byte_t d);
        @(posedge clk);
        #1 cv = 1;
        cc = c;
        cd = d;
        @(posedge clk);
        #1 cv = 0;
    endtask
    // Query: note the expected answer, then send the command
    task automatic q(input gsr_cmd_e c, input gsr_byte_t e);
        exq.push_back(e);
        cmd(c, 8'h00);
    endtask
    task automatic pulse(ref logic s);
        @(posedge clk);
        #1 s = 1;
        @(posedge clk);
        #1 s = 0;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic close_out();
        if (exq.size() != 0) failures++;
        if (failures == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Answer watcher: each strobe takes the oldest note
    always @(negedge clk) if (rv === 1'b1) begin
        if (exq.size() == 0) cmp("stray answer", 8'hFF, rd);
        else cmp("answer", exq.pop_front(), rd);
    end
    initial begin
        #100000;
        failures++;
        close_out();
    end
    initial begin
        void'($urandom(32'hD5B54F97));
        r = 8'($urandom);
        tc = 8'($urandom);
        sc = 8'($urandom);
        wt(10);
        rst = 0;
        q(GSR_CMD_Q_ESR, 8'h80);
        q(GSR_CMD_Q_ESR, 8'h00);
        q(GSR_CMD_Q_SRE, 8'h00);
        q(GSR_CMD_Q_QER, 8'h00);
        q(GSR_CMD_Q_ITR, tc & 8'h86);
        cmp("input_enable", 8'h00, {7'h0, ie});
        q(GSR_CMD_Q_ISR, (sc & 8'h8E) | 8'h01);
        cmd(GSR_CMD_SET_ISE, 8'h01);
        q(GSR_CMD_Q_STB, 8'h01);
        cmd(GSR_CMD_SET_ISE, 8'h00);
        cmd(GSR_CMD_SET_PRE, r);
        q(GSR_CMD_Q_PRE, r);
        cmd(GSR_CMD_SET_SRE, 8'h10);
        q(GSR_CMD_Q_SRE, 8'h10);
        cmd(GSR_CMD_SET_PRE, 8'h10);
        pulse(rr);
        wt(3);
        cmp("mav", 8'h01, {7'h0, mav});
        cmp("srq", 8'h01, {7'h0, srq});
        cmp("poll byte", 8'h50, sb);
        q(GSR_CMD_Q_IST, 8'h01);
        gsr_ctl_model_i.spoll();
        wt(2);
        cmp("srq", 8'h00, {7'h0, srq});
        cmp("poll byte", 8'h10, sb);
        q(GSR_CMD_Q_STB, 8'h50);
        pulse(ts);
        wt(3);
        cmp("mav", 8'h00, {7'h0, mav});
        q(GSR_CMD_Q_STB, 8'h00);
        pulse(rr);
        wt(2);
        pulse(qf);
        wt(2);
        pulse(ce);
        q(GSR_CMD_Q_QER, 8'h02);
        q(GSR_CMD_Q_ESR, 8'h24);
        pulse(rr);
        wt(2);
        pulse(tp);
        wt(2);
        q(GSR_CMD_Q_QER, 8'h01);
        gsr_ctl_model_i.talk();
        wt(3);
        q(GSR_CMD_Q_QER, 8'h03);
        cmd(GSR_CMD_CLS, 8'h00);
        q(GSR_CMD_Q_ESR, 8'h00);
        pulse(rr);
        cmd(GSR_CMD_PPE, 8'h0B);
        gsr_ctl_model_i.ppoll(1'b1);
        wt(4);
        cmp("dio_oe", 8'h08, doe);
        cmp("dio_o", 8'h00, doo);
        cmd(GSR_CMD_PPD, 8'h00);
        wt(2);
        cmp("dio_oe", 8'h00, doe);
        gsr_ctl_model_i.ppoll(1'b0);
        wt(4);
        close_out();
    end
endmodule
`default_nettype wire
